// ==== phy_xcvr_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef PHY_XCVR_REGS_SVH
`define PHY_XCVR_REGS_SVH

`define CTRL_OFFSET 32'h0000_00b4
`define STAT_OFFSET 32'h0000_00b8

`define CTRL_RESET_POS 15
`define CTRL_LOOP_POS 14
`define CTRL_SPEED_POS 13
`define CTRL_AN_EN_POS 12
`define CTRL_PDOWN_POS 11
`define CTRL_RESTART_POS 9
`define CTRL_DUPLEX_POS 8
`define CTRL_COLTEST_POS 7
`define CTRL_WMASK 16'hfb80
`define CTRL_RESET_VAL 16'h1000

`define STAT_FOUR_PAIR_POS 15
`define STAT_TX_FD_POS 14
`define STAT_TX_HD_POS 13
`define STAT_T10_FD_POS 12
`define STAT_T10_HD_POS 11
`define STAT_AN_DONE_POS 5
`define STAT_RFAULT_POS 4
`define STAT_AN_ABLE_POS 3
`define STAT_LINK_POS 2
`define STAT_JABBER_POS 1
`define STAT_EXT_POS 0

`define MAC_MODE_LOOP_OK 2'h0
`define XCVR_RESET_CYCLES 16

`endif

// ==== phy_xcvr_pkg.sv ====
// Types shared by the transceiver control and status bank
package phy_xcvr_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_RESET = 3'b010,
    SEQ_RESTART = 3'b100
  } seq_e;

  typedef logic [1:0] mac_mode_t;

  typedef struct packed {
    seq_e seq;
    logic [15:0] ctrl;
    logic [15:0] cnt;
    logic wr_pend;
    logic wr_ctrl;
    logic link_lat;
    logic rf_lat;
    logic jab_lat;
    logic [31:0] rdata;
    logic readyout;
    logic resp;
    logic xcvr_reset;
    logic loopback_en;
    logic speed_100;
    logic full_duplex;
    logic autoneg_en;
    logic autoneg_restart;
    logic power_down;
    logic collision_test;
  } state_s;

endpackage

// ==== phy_transceiver_control_status.sv ====
// Transceiver control and status registers behind an AHB-Lite slave
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "phy_xcvr_regs.svh"

module phy_transceiver_control_status #(
  parameter int unsigned RESET_CYCLES = `XCVR_RESET_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire phy_xcvr_pkg::mac_mode_t mac_operating_mode_field,
  input wire logic link_up,
  input wire logic an_complete,
  input wire logic an_speed_100,
  input wire logic an_full_duplex,
  input wire logic remote_fault,
  input wire logic jabber,
  output logic xcvr_reset,
  output logic loopback_en,
  output logic speed_100,
  output logic full_duplex,
  output logic autoneg_en,
  output logic autoneg_restart,
  output logic power_down,
  output logic collision_test
);
  import phy_xcvr_pkg::*;

  localparam state_s STATE_RESET = '{
    seq: SEQ_IDLE,
    ctrl: `CTRL_RESET_VAL,
    cnt: 16'h0000,
    wr_pend: 1'b0,
    wr_ctrl: 1'b0,
    link_lat: 1'b0,
    rf_lat: 1'b0,
    jab_lat: 1'b0,
    rdata: 32'h0000_0000,
    readyout: 1'b1,
    resp: 1'b0,
    xcvr_reset: 1'b0,
    loopback_en: 1'b0,
    speed_100: 1'b0,
    full_duplex: 1'b0,
    autoneg_en: 1'b1,
    autoneg_restart: 1'b0,
    power_down: 1'b0,
    collision_test: 1'b0
  };

  state_s s;
  state_s next_s;
  logic access;
  logic rd_stat;
  logic rd_ctrl;

  // Word address match
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] off);
    hit = (addr[31:2] == off[31:2]);
  endfunction

  // Status word from latched and live flags
  function automatic logic [15:0] status_word(input logic anc, input logic rf,
                                              input logic lnk, input logic jab);
    logic [15:0] w;
    w = 16'h0000;
    // Fixed abilities
    // full duplex one
    w[`STAT_TX_FD_POS] = 1'b1;
    w[`STAT_TX_HD_POS] = 1'b1;
    w[`STAT_FOUR_PAIR_POS] = 1'b0;
    w[`STAT_T10_FD_POS] = 1'b1;
    w[`STAT_T10_HD_POS] = 1'b1;
    w[`STAT_AN_ABLE_POS] = 1'b1;
    w[`STAT_EXT_POS] = 1'b1;
    w[`STAT_AN_DONE_POS] = anc;
    w[`STAT_RFAULT_POS] = rf;
    w[`STAT_LINK_POS] = lnk;
    w[`STAT_JABBER_POS] = jab;
    status_word = w;
  endfunction

  always_comb begin
    access = hsel && htrans[1] && hready;
    rd_stat = access && !hwrite && hit(haddr, `STAT_OFFSET);
    rd_ctrl = access && !hwrite && hit(haddr, `CTRL_OFFSET);
    next_s = s;
    next_s.readyout = 1'b1;
    next_s.resp = 1'b0;
    next_s.autoneg_restart = 1'b0;

    // Reset and restart sequencer
    case (s.seq)
      SEQ_IDLE: begin
        if (s.ctrl[`CTRL_RESET_POS]) begin
          next_s.seq = SEQ_RESET;
          next_s.cnt = 16'(RESET_CYCLES - 1);
        end else if (s.ctrl[`CTRL_RESTART_POS]) begin
          next_s.seq = SEQ_RESTART;
          next_s.autoneg_restart = 1'b1;
        end
      end
      SEQ_RESET: begin
        if (s.cnt == 16'h0000) begin
          next_s.ctrl[`CTRL_RESET_POS] = 1'b0;
          next_s.seq = SEQ_IDLE;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      SEQ_RESTART: begin
        next_s.ctrl[`CTRL_RESTART_POS] = 1'b0;
        next_s.seq = SEQ_IDLE;
      end
      default: begin
        next_s.seq = SEQ_IDLE;
      end
    endcase

    // Write data phase, after hardware clear so a new set wins
    // masked write
    if (s.wr_pend && s.wr_ctrl) begin
      next_s.ctrl = hwdata[15:0] & `CTRL_WMASK;
    end

    // Address phase capture, status writes dropped
    // status not writable
    next_s.wr_pend = access && hwrite;
    next_s.wr_ctrl = access && hwrite && hit(haddr, `CTRL_OFFSET);

    // Latched flags, a new event beats a read clear
    // link latch low
    if (rd_stat) begin
      next_s.link_lat = link_up;
      next_s.rf_lat = remote_fault;
      next_s.jab_lat = jabber;
    end else begin
      next_s.link_lat = link_up && s.link_lat;
      next_s.rf_lat = remote_fault || s.rf_lat;
      next_s.jab_lat = jabber || s.jab_lat;
    end

    // Read data
    if (rd_ctrl) begin
      next_s.rdata = {16'h0000, next_s.ctrl};
    end else if (rd_stat) begin
      next_s.rdata = {16'h0000, status_word(an_complete, s.rf_lat || remote_fault,
                                            s.link_lat && link_up, s.jab_lat || jabber)};
    end else begin
      next_s.rdata = 32'h0000_0000;
    end

    // Transceiver controls
    next_s.xcvr_reset = (next_s.seq == SEQ_RESET);
    next_s.loopback_en = next_s.ctrl[`CTRL_LOOP_POS] &&
                         (mac_operating_mode_field == `MAC_MODE_LOOP_OK);
    next_s.autoneg_en = next_s.ctrl[`CTRL_AN_EN_POS];
    next_s.speed_100 = next_s.ctrl[`CTRL_AN_EN_POS] ? an_speed_100 :
                       next_s.ctrl[`CTRL_SPEED_POS];
    next_s.full_duplex = next_s.ctrl[`CTRL_AN_EN_POS] ? an_full_duplex :
                         next_s.ctrl[`CTRL_DUPLEX_POS];
    next_s.power_down = next_s.ctrl[`CTRL_PDOWN_POS];
    next_s.collision_test = next_s.ctrl[`CTRL_COLTEST_POS];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata = s.rdata;
  assign hreadyout = s.readyout;
  assign hresp = s.resp;
  assign xcvr_reset = s.xcvr_reset;
  assign loopback_en = s.loopback_en;
  assign speed_100 = s.speed_100;
  assign full_duplex = s.full_duplex;
  assign autoneg_en = s.autoneg_en;
  assign autoneg_restart = s.autoneg_restart;
  assign power_down = s.power_down;
  assign collision_test = s.collision_test;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_reset_start;
    $rose(s.ctrl[`CTRL_RESET_POS]) |=> xcvr_reset;
  endproperty
  a_reset_start: assert property (p_reset_start)
    else $error("transceiver reset not started");

  property p_reset_len;
    $rose(xcvr_reset) |-> s.cnt == 16'(RESET_CYCLES - 1);
  endproperty
  a_reset_len: assert property (p_reset_len)
    else $error("reset count wrong at start");

  property p_reset_done;
    (s.seq == SEQ_RESET && s.cnt == 16'h0000 && !(s.wr_pend && s.wr_ctrl))
      |=> !s.ctrl[`CTRL_RESET_POS] && !xcvr_reset;
  endproperty
  a_reset_done: assert property (p_reset_done)
    else $error("reset bit not cleared at end");

  property p_loop;
    loopback_en |-> $past(mac_operating_mode_field) == `MAC_MODE_LOOP_OK &&
                    s.ctrl[`CTRL_LOOP_POS];
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback with wrong mac mode");

  property p_speed;
    speed_100 == (s.ctrl[`CTRL_AN_EN_POS] ? $past(an_speed_100) : s.ctrl[`CTRL_SPEED_POS]);
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed select wrong");

  property p_an;
    autoneg_en == s.ctrl[`CTRL_AN_EN_POS];
  endproperty
  a_an: assert property (p_an)
    else $error("autoneg enable mismatch");

  property p_pdown;
    power_down == s.ctrl[`CTRL_PDOWN_POS] && collision_test == s.ctrl[`CTRL_COLTEST_POS];
  endproperty
  a_pdown: assert property (p_pdown)
    else $error("power down or collision test mismatch");

  property p_restart;
    (s.seq == SEQ_IDLE && s.ctrl[`CTRL_RESTART_POS] && !s.ctrl[`CTRL_RESET_POS])
      |=> autoneg_restart ##1 !autoneg_restart;
  endproperty
  a_restart: assert property (p_restart)
    else $error("autoneg restart pulse wrong");

  property p_duplex;
    full_duplex == (s.ctrl[`CTRL_AN_EN_POS] ? $past(an_full_duplex) :
                    s.ctrl[`CTRL_DUPLEX_POS]);
  endproperty
  a_duplex: assert property (p_duplex)
    else $error("duplex select wrong");

  property p_status_fixed;
    rd_stat |=> hrdata[15:11] == 5'h0f && hrdata[10:6] == 5'h00 && hrdata[31:16] == 16'h0000;
  endproperty
  a_status_fixed: assert property (p_status_fixed)
    else $error("fixed status bits wrong");

  property p_link;
    (!link_up ##1 rd_stat) |=> !hrdata[`STAT_LINK_POS];
  endproperty
  a_link: assert property (p_link)
    else $error("link failure not latched");

  property p_ctrl_rsv;
    rd_ctrl |=> (hrdata[15:0] & ~`CTRL_WMASK) == 16'h0000 && hrdata[31:16] == 16'h0000;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv)
    else $error("reserved control bits nonzero");

  property p_bus_ok;
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok)
    else $error("bus answer not okay");

  property p_coltest;
    collision_test == s.ctrl[`CTRL_COLTEST_POS];
  endproperty
  a_coltest: assert property (p_coltest)
    else $error("collision test mismatch");

  property p_restart_clear;
    (s.seq == SEQ_RESTART && !(s.wr_pend && s.wr_ctrl)) |=> !s.ctrl[`CTRL_RESTART_POS];
  endproperty
  a_restart_clear: assert property (p_restart_clear)
    else $error("restart bit not cleared");

  property p_status_abilities;
    rd_stat |=> hrdata[`STAT_TX_FD_POS] && hrdata[`STAT_TX_HD_POS] &&
                !hrdata[`STAT_FOUR_PAIR_POS];
  endproperty
  a_status_abilities: assert property (p_status_abilities)
    else $error("ability bits wrong");

  property p_cov_reset;
    xcvr_reset ##1 !xcvr_reset;
  endproperty
  c_cov_reset: cover property (p_cov_reset);

  property p_cov_restart;
    autoneg_restart;
  endproperty
  c_cov_restart: cover property (p_cov_restart);

  property p_cov_link_drop;
    !link_up ##1 link_up ##1 rd_stat;
  endproperty
  c_cov_link_drop: cover property (p_cov_link_drop);

  property p_cov_loop;
    loopback_en;
  endproperty
  c_cov_loop: cover property (p_cov_loop);

endmodule

`default_nettype wire

// ==== phy_link_partner.sv ====
// Behavioural line side: link level and autonegotiation outcome
`timescale 1ns/10ps
`default_nettype none
module phy_link_partner #(
  parameter int NEG_CYCLES = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cable,
  input wire logic xcvr_reset,
  input wire logic autoneg_restart,
  input wire logic power_down,
  output logic link_up,
  output logic an_complete,
  output logic an_speed_100,
  output logic an_full_duplex
);
  int cnt;
  always_ff @(posedge mclk) begin
    link_up <= cable && !power_down && !xcvr_reset && !rst;
    if (rst) begin
      cnt <= 0;
      an_complete <= 1'b0;
    end else if (xcvr_reset || autoneg_restart) begin
      cnt <= NEG_CYCLES;
      an_complete <= 1'b0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      an_complete <= 1'b1;
    end
  end
  // Far end offers 100 Mb/s full duplex once negotiated
  assign an_speed_100 = an_complete;
  assign an_full_duplex = an_complete;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the transceiver control and status bank
`timescale 1ns/10ps
`default_nettype none
`include "phy_xcvr_regs.svh"
module tb_top;
  import phy_xcvr_pkg::*;
  localparam int RC = 4;
  typedef struct packed {
    mac_mode_t mode;
    logic [15:0] wr;
    logic [15:0] rd;
    logic [5:0] outs;
  } row_s;
  row_s rows [8] = '{
    '{2'h0, 16'h0000, 16'h0000, 6'h00},
    '{2'h0, 16'h2100, 16'h2100, 6'h18},
    '{2'h0, 16'h3100, 16'h3100, 6'h04},
    '{2'h1, 16'h4000, 16'h4000, 6'h00},
    '{2'h0, 16'h4000, 16'h4000, 6'h20},
    '{2'h0, 16'h0800, 16'h0800, 6'h02},
    '{2'h0, 16'h0080, 16'h0080, 6'h01},
    '{2'h0, 16'h7dff, 16'h7980, 6'h27}
  };
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  mac_mode_t mac_mode = 2'h0;
  logic cable = 1'b1;
  logic [31:0] hrdata;
  logic hreadyout, hresp, link_up, an_complete, an_speed_100, an_full_duplex;
  logic xcvr_reset, loopback_en, speed_100, full_duplex;
  logic autoneg_en, autoneg_restart, power_down, collision_test;
  int failures = 0;
  int checks = 0;

  phy_transceiver_control_status #(.RESET_CYCLES(RC)) i_phy_transceiver_control_status (
    .mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .mac_operating_mode_field(mac_mode), .link_up, .an_complete, .an_speed_100,
    .an_full_duplex, .remote_fault(1'b0), .jabber(1'b0), .xcvr_reset, .loopback_en,
    .speed_100, .full_duplex, .autoneg_en, .autoneg_restart, .power_down, .collision_test
  );

  phy_link_partner i_phy_link_partner (
    .mclk, .rst, .cable, .xcvr_reset, .autoneg_restart, .power_down,
    .link_up, .an_complete, .an_speed_100, .an_full_duplex
  );

  always #4 mclk = ~mclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Single AHB-Lite transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask

  initial begin
    #40000;
    failures++;
    end_sim();
  end

  initial begin
    logic [31:0] q;
    int n;
    @(posedge mclk);
    #1;
    check({hresp, hreadyout, hrdata[29:0]}, 32'h4000_0000);
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(`CTRL_OFFSET, q);
    check(q, 32'h0000_1000);
    rd(`STAT_OFFSET, q);
    check(q, 32'h0000_7809);
    rd(`STAT_OFFSET, q);
    check(q, 32'h0000_780d);
    bus(1'b1, `STAT_OFFSET, 32'h0000_ffff, q);
    rd(`STAT_OFFSET, q);
    check(q, 32'h0000_780d);
    cable <= 1'b0;
    repeat (3) @(posedge mclk);
    cable <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(`STAT_OFFSET, q);
    check(q, 32'h0000_7809);
    rd(`STAT_OFFSET, q);
    check(q, 32'h0000_780d);
    rd(32'h0000_00c0, q);
    check(q, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      mac_mode <= rows[i].mode;
      bus(1'b1, `CTRL_OFFSET, {16'h0000, rows[i].wr}, q);
      rd(`CTRL_OFFSET, q);
      check(q, {16'h0000, rows[i].rd});
      #1;
      check({26'h0, loopback_en, speed_100, full_duplex, autoneg_en, power_down,
             collision_test}, {26'h0, rows[i].outs});
    end
    bus(1'b1, `CTRL_OFFSET, 32'h0000_8000, q);
    @(posedge mclk);
    #1;
    check({31'h0, xcvr_reset}, 32'h1);
    n = 0;
    while (xcvr_reset === 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check(n, RC);
    rd(`CTRL_OFFSET, q);
    check(q, 32'h0000_0000);
    bus(1'b1, `CTRL_OFFSET, 32'h0000_1200, q);
    @(posedge mclk);
    #1;
    check({31'h0, autoneg_restart}, 32'h1);
    @(posedge mclk);
    #1;
    check({31'h0, autoneg_restart}, 32'h0);
    rd(`CTRL_OFFSET, q);
    check(q, 32'h0000_1000);
    repeat (12) @(posedge mclk);
    rd(`STAT_OFFSET, q);
    rd(`STAT_OFFSET, q);
    check(q, 32'h0000_782d);
    #1;
    check({30'h0, speed_100, full_duplex}, 32'h3);
    end_sim();
  end
endmodule
`default_nettype wire
